// ---- hw/timer_capture_pkg.sv ----
// constants, types and state layout of the timer pair with input capture
// Operation
// - low-word run bit starts the 32-bit pair when joined, else the low timer.
// - gate-accumulate counts only while gate is high; ignored with external clock.
// - prescale codes 00,01,10,11 divide by 1, 8, 64 and 256.
// - join bit 3 makes one 32-bit timer; clear gives two 16-bit timers.
// - clock-source bit picks external pin rising edges, else instruction clock.
// - each timer idle-halt bit stops that timer during Idle.
// - while joined, upper-word control bits have no effect on counting, except its idle-halt bit, which also stops the pair.
// - unimplemented control bits read as zero.
// - a capture event latches the selected 16-bit timer value.
// - mode field decodes off, every edge, fall, rise, 4th, 16th, disabled.
// - mode 111 uses pin only as rising-edge interrupt during Sleep or Idle.
// - captures-per-interrupt raises the interrupt after 1, 2, 3 or 4 captures; every-edge mode interrupts on each capture.
// - captured values wait in a four-word first-in first-out buffer.
// - read-only overflow flag, cleared by hardware only.
// - read-only not-empty flag reflects unread values, hardware cleared.
// - timer-select set captures first timer, clear captures second timer.
// - capture idle-halt bit stops the capture channel during Idle.
// - a capture pin event wakes the device from Sleep and Idle.
// - joined, lower timer is low word and higher timer the high word.
// - joined, low-word inputs drive the pair; match flags the upper timer.
package timer_capture_pkg;

    localparam int          ADDR_W         = 8;
    localparam logic [7:0]  OFS_LOW_CTRL   = 8'h00;
    localparam logic [7:0]  OFS_HIGH_CTRL  = 8'h04;
    localparam logic [7:0]  OFS_CAP_CTRL   = 8'h08;
    localparam logic [7:0]  OFS_CAP_BUF    = 8'h0C;
    localparam logic [7:0]  OFS_CNT_LOW    = 8'h10;
    localparam logic [7:0]  OFS_CNT_HIGH   = 8'h14;
    localparam logic [7:0]  OFS_PER_LOW    = 8'h18;
    localparam logic [7:0]  OFS_PER_HIGH   = 8'h1C;

    localparam int          BIT_RUN        = 15;
    localparam int          BIT_IDLE_HALT  = 13;
    localparam int          BIT_GATE       = 6;
    localparam int          BIT_PRE_LO     = 4;
    localparam int          BIT_JOIN       = 3;
    localparam int          BIT_CLK_SRC    = 1;
    localparam int          BIT_CAP_TSEL   = 7;
    localparam int          BIT_CPI_LO     = 5;
    localparam int          BIT_OVF        = 4;
    localparam int          BIT_BNE        = 3;

    localparam logic [15:0] LOW_CTRL_MASK  = 16'hA07A;
    localparam logic [15:0] HIGH_CTRL_MASK = 16'hA072;
    localparam logic [15:0] CAP_CTRL_MASK  = 16'h20E7;
    localparam logic [15:0] CTRL_RESET     = 16'h0000;
    localparam logic [15:0] COUNT_RESET    = 16'h0000;
    localparam logic [15:0] PERIOD_RESET   = 16'hFFFF;

    localparam logic [7:0]  PRE_LIM_1      = 8'h00;
    localparam logic [7:0]  PRE_LIM_8      = 8'h07;
    localparam logic [7:0]  PRE_LIM_64     = 8'h3F;
    localparam logic [7:0]  PRE_LIM_256    = 8'hFF;
    localparam logic [3:0]  EDGE_LIM_4     = 4'h3;
    localparam logic [3:0]  EDGE_LIM_16    = 4'hF;
    localparam logic [2:0]  FIFO_DEPTH     = 3'h4;

    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef enum logic [2:0] {
        CAP_OFF      = 3'b000,
        CAP_EVERY    = 3'b001,
        CAP_FALL     = 3'b010,
        CAP_RISE     = 3'b011,
        CAP_RISE4    = 3'b100,
        CAP_RISE16   = 3'b101,
        CAP_DISABLED = 3'b110,
        CAP_WAKE     = 3'b111
    } cap_mode_e;

    typedef struct packed {
        logic [15:0]       low_ctrl;
        logic [15:0]       high_ctrl;
        logic [15:0]       cap_ctrl;
        logic [15:0]       cnt_low;
        logic [15:0]       cnt_high;
        logic [15:0]       per_low;
        logic [15:0]       per_high;
        logic [7:0]        pre_low;
        logic [7:0]        pre_high;
        logic              ext_low_prev;
        logic              ext_high_prev;
        logic              pin_prev;
        logic [3:0][15:0]  fifo;
        logic [1:0]        wr_ptr;
        logic [1:0]        rd_ptr;
        logic [2:0]        fill;
        logic              overflow;
        logic [3:0]        edge_cnt;
        logic [1:0]        cap_cnt;
        logic              aw_have;
        logic              w_have;
        logic [ADDR_W-1:0] aw_addr;
        logic [31:0]       w_data;
        logic [3:0]        w_strb;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic              cap_irq;
        logic              low_irq;
        logic              high_irq;
        logic              wake;
    } state_s;

endpackage

// ---- hw/timer_pair_input_capture.sv ----
// timer pair with joinable 32-bit mode and four-word input capture channel
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/10ps
module timer_pair_input_capture (
    input  wire logic                                 clk_i,
    input  wire logic                                 rstn_i,
    input  wire logic [timer_capture_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic                                 s_axi_awvalid_i,
    output logic                                      s_axi_awready_o,
    input  wire logic [31:0]                          s_axi_wdata_i,
    input  wire logic [3:0]                           s_axi_wstrb_i,
    input  wire logic                                 s_axi_wvalid_i,
    output logic                                      s_axi_wready_o,
    output logic [1:0]                                s_axi_bresp_o,
    output logic                                      s_axi_bvalid_o,
    input  wire logic                                 s_axi_bready_i,
    input  wire logic [timer_capture_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic                                 s_axi_arvalid_i,
    output logic                                      s_axi_arready_o,
    output logic [31:0]                               s_axi_rdata_o,
    output logic [1:0]                                s_axi_rresp_o,
    output logic                                      s_axi_rvalid_o,
    input  wire logic                                 s_axi_rready_i,
    input  wire logic                                 idle_i,
    input  wire logic                                 sleep_i,
    input  wire logic                                 gate_low_i,
    input  wire logic                                 gate_high_i,
    input  wire logic                                 external_count_pin_low_i,
    input  wire logic                                 external_count_pin_high_i,
    input  wire logic                                 capture_input_pin_i,
    output logic                                      capture_irq_o,
    output logic                                      timer_low_irq_o,
    output logic                                      timer_high_irq_o,
    output logic                                      wake_o
);
    import timer_capture_pkg::*;

    state_s s_reg;
    state_s s_next;

    function automatic logic [7:0] pre_limit(input logic [1:0] sel);
        logic [7:0] lim;
        lim = PRE_LIM_1;
        unique case (sel)
            2'b00: lim = PRE_LIM_1;
            2'b01: lim = PRE_LIM_8;
            2'b10: lim = PRE_LIM_64;
            2'b11: lim = PRE_LIM_256;
        endcase
        return lim;
    endfunction

    // raw count request before the prescaler
    function automatic logic tick_source(input logic [15:0] ctrl,
                                         input logic        ext_rise,
                                         input logic        gate);
        logic t;
        t = 1'b1;
        if (ctrl[BIT_CLK_SRC]) begin
            t = ext_rise;
        end else if (ctrl[BIT_GATE]) begin
            t = gate;
        end
        return t;
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb,
                                            input logic [15:0] mask);
        logic [15:0] v;
        v = old;
        if (strb[0]) begin
            v[7:0] = data[7:0];
        end
        if (strb[1]) begin
            v[15:8] = data[15:8];
        end
        return v & mask;
    endfunction

    logic              join_on;
    logic              low_in;
    logic              high_in;
    logic              low_step;
    logic              high_step;
    logic              ext_low_rise;
    logic              ext_high_rise;
    logic              pin_rise;
    logic              pin_fall;
    logic              cap_active;
    logic              cap_event;
    logic              edge_hit;
    logic              pop;
    logic              push;
    logic [2:0]        fill_after_pop;
    logic [15:0]       cap_value;
    logic [15:0]       cap_status;
    logic              aw_ok;
    logic              w_ok;
    logic [ADDR_W-1:0] waddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              do_write;
    logic              do_read;
    cap_mode_e         mode;

    always_comb begin
        s_next = s_reg;
        s_next.cap_irq = 1'b0;
        s_next.low_irq = 1'b0;
        s_next.high_irq = 1'b0;
        s_next.wake = 1'b0;
        s_next.ext_low_prev = external_count_pin_low_i;
        s_next.ext_high_prev = external_count_pin_high_i;
        s_next.pin_prev = capture_input_pin_i;

        ext_low_rise = external_count_pin_low_i & ~s_reg.ext_low_prev;
        ext_high_rise = external_count_pin_high_i & ~s_reg.ext_high_prev;
        pin_rise = capture_input_pin_i & ~s_reg.pin_prev;
        pin_fall = ~capture_input_pin_i & s_reg.pin_prev;
        join_on = s_reg.low_ctrl[BIT_JOIN];

        // low-word control drives the pair when joined
        low_in = s_reg.low_ctrl[BIT_RUN]
                 & ~(idle_i & s_reg.low_ctrl[BIT_IDLE_HALT]);
        if (join_on) begin
            // either idle-halt bit stops the joined pair
            low_in = low_in
                     & ~(idle_i & s_reg.high_ctrl[BIT_IDLE_HALT]);
        end
        low_in = low_in & tick_source(s_reg.low_ctrl, ext_low_rise,
                                      gate_low_i);
        high_in = s_reg.high_ctrl[BIT_RUN]
                  & ~(idle_i & s_reg.high_ctrl[BIT_IDLE_HALT])
                  & tick_source(s_reg.high_ctrl, ext_high_rise,
                                gate_high_i) & ~join_on;

        low_step = 1'b0;
        if (low_in) begin
            if (s_reg.pre_low >= pre_limit(
                    s_reg.low_ctrl[BIT_PRE_LO +: 2])) begin
                s_next.pre_low = 8'h00;
                low_step = 1'b1;
            end else begin
                s_next.pre_low = s_reg.pre_low + 8'h01;
            end
        end
        high_step = 1'b0;
        if (high_in) begin
            if (s_reg.pre_high >= pre_limit(
                    s_reg.high_ctrl[BIT_PRE_LO +: 2])) begin
                s_next.pre_high = 8'h00;
                high_step = 1'b1;
            end else begin
                s_next.pre_high = s_reg.pre_high + 8'h01;
            end
        end

        if (join_on) begin
            if (low_step) begin
                if ({s_reg.cnt_high, s_reg.cnt_low}
                    == {s_reg.per_high, s_reg.per_low}) begin
                    s_next.cnt_low = COUNT_RESET;
                    s_next.cnt_high = COUNT_RESET;
                    s_next.high_irq = 1'b1;
                end else begin
                    {s_next.cnt_high, s_next.cnt_low} =
                        {s_reg.cnt_high, s_reg.cnt_low} + 32'h0000_0001;
                end
            end
        end else begin
            if (low_step) begin
                if (s_reg.cnt_low == s_reg.per_low) begin
                    s_next.cnt_low = COUNT_RESET;
                    s_next.low_irq = 1'b1;
                end else begin
                    s_next.cnt_low = s_reg.cnt_low + 16'h0001;
                end
            end
            if (high_step) begin
                if (s_reg.cnt_high == s_reg.per_high) begin
                    s_next.cnt_high = COUNT_RESET;
                    s_next.high_irq = 1'b1;
                end else begin
                    s_next.cnt_high = s_reg.cnt_high + 16'h0001;
                end
            end
        end

        // capture channel
        mode = cap_mode_e'(s_reg.cap_ctrl[2:0]);
        cap_active = ~(idle_i & s_reg.cap_ctrl[BIT_IDLE_HALT]);
        edge_hit = 1'b0;
        cap_event = 1'b0;
        unique case (mode)
            CAP_EVERY: cap_event = pin_rise | pin_fall;
            CAP_FALL:  cap_event = pin_fall;
            CAP_RISE:  cap_event = pin_rise;
            CAP_RISE4: begin
                edge_hit = s_reg.edge_cnt >= EDGE_LIM_4;
                cap_event = pin_rise & edge_hit;
            end
            CAP_RISE16: begin
                edge_hit = s_reg.edge_cnt >= EDGE_LIM_16;
                cap_event = pin_rise & edge_hit;
            end
            CAP_OFF, CAP_DISABLED, CAP_WAKE: cap_event = 1'b0;
        endcase
        cap_event = cap_event & cap_active;
        if (cap_active && pin_rise
            && (mode == CAP_RISE4 || mode == CAP_RISE16)) begin
            s_next.edge_cnt = edge_hit ? 4'h0 : s_reg.edge_cnt + 4'h1;
        end

        // timer-select polarity kept as printed
        cap_value = s_reg.cap_ctrl[BIT_CAP_TSEL] ? s_reg.cnt_low
                                                  : s_reg.cnt_high;

        do_read = s_axi_arvalid_i & s_reg.arready & ~s_reg.rvalid;
        pop = do_read && (s_axi_araddr_i == OFS_CAP_BUF)
              && (s_reg.fill != 3'h0);
        fill_after_pop = s_reg.fill - {2'b00, pop};
        push = cap_event && (fill_after_pop != FIFO_DEPTH);
        if (pop) begin
            s_next.rd_ptr = s_reg.rd_ptr + 2'h1;
        end
        if (push) begin
            s_next.fifo[s_reg.wr_ptr] = cap_value;
            s_next.wr_ptr = s_reg.wr_ptr + 2'h1;
            // every-edge mode interrupts on each capture, field ignored
            if (mode == CAP_EVERY
                || s_reg.cap_cnt >= s_reg.cap_ctrl[BIT_CPI_LO +: 2]) begin
                s_next.cap_cnt = 2'h0;
                s_next.cap_irq = 1'b1;
            end else begin
                s_next.cap_cnt = s_reg.cap_cnt + 2'h1;
            end
        end
        s_next.fill = fill_after_pop + {2'b00, push};
        // clear on draining, but a new overflow in the same cycle wins
        if (pop && fill_after_pop == 3'h0) begin
            s_next.overflow = 1'b0;
        end
        if (cap_event && !push) begin
            s_next.overflow = 1'b1;
        end
        if (mode == CAP_WAKE && pin_rise && (sleep_i || idle_i)) begin
            s_next.cap_irq = 1'b1;
            s_next.wake = 1'b1;
        end
        if (cap_event && (sleep_i || idle_i)) begin
            s_next.wake = 1'b1;
        end
        if (mode == CAP_OFF) begin
            s_next.wr_ptr = 2'h0;
            s_next.rd_ptr = 2'h0;
            s_next.fill = 3'h0;
            s_next.overflow = 1'b0;
            s_next.edge_cnt = 4'h0;
            s_next.cap_cnt = 2'h0;
        end

        cap_status = s_reg.cap_ctrl & CAP_CTRL_MASK;
        cap_status[BIT_OVF] = s_reg.overflow;
        cap_status[BIT_BNE] = s_reg.fill != 3'h0;

        // write channel: address and data may arrive in either order
        aw_ok = s_reg.aw_have | (s_axi_awvalid_i & s_reg.awready);
        w_ok = s_reg.w_have | (s_axi_wvalid_i & s_reg.wready);
        waddr = s_reg.aw_have ? s_reg.aw_addr : s_axi_awaddr_i;
        wdata = s_reg.w_have ? s_reg.w_data : s_axi_wdata_i;
        wstrb = s_reg.w_have ? s_reg.w_strb : s_axi_wstrb_i;
        if (s_axi_awvalid_i && s_reg.awready) begin
            s_next.aw_have = 1'b1;
            s_next.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_reg.wready) begin
            s_next.w_have = 1'b1;
            s_next.w_data = s_axi_wdata_i;
            s_next.w_strb = s_axi_wstrb_i;
        end
        if (s_reg.bvalid && s_axi_bready_i) begin
            s_next.bvalid = 1'b0;
        end
        do_write = aw_ok & w_ok & ~s_reg.bvalid;
        if (do_write) begin
            s_next.aw_have = 1'b0;
            s_next.w_have = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = RESP_OKAY;
            // software writes take priority over counting
            unique case (waddr)
                OFS_LOW_CTRL: s_next.low_ctrl = merge16(s_reg.low_ctrl,
                    wdata, wstrb, LOW_CTRL_MASK);
                OFS_HIGH_CTRL: s_next.high_ctrl = merge16(s_reg.high_ctrl,
                    wdata, wstrb, HIGH_CTRL_MASK);
                OFS_CAP_CTRL: s_next.cap_ctrl = merge16(s_reg.cap_ctrl,
                    wdata, wstrb, CAP_CTRL_MASK & ~16'h0018);
                OFS_CNT_LOW: s_next.cnt_low = merge16(s_reg.cnt_low,
                    wdata, wstrb, 16'hFFFF);
                OFS_CNT_HIGH: s_next.cnt_high = merge16(s_reg.cnt_high,
                    wdata, wstrb, 16'hFFFF);
                OFS_PER_LOW: s_next.per_low = merge16(s_reg.per_low,
                    wdata, wstrb, 16'hFFFF);
                OFS_PER_HIGH: s_next.per_high = merge16(s_reg.per_high,
                    wdata, wstrb, 16'hFFFF);
                OFS_CAP_BUF: s_next.bresp = RESP_OKAY;
                default: s_next.bresp = RESP_SLVERR;
            endcase
        end
        s_next.awready = ~s_next.aw_have;
        s_next.wready = ~s_next.w_have;

        // read channel
        if (s_reg.rvalid && s_axi_rready_i) begin
            s_next.rvalid = 1'b0;
        end
        if (do_read) begin
            s_next.rvalid = 1'b1;
            s_next.rresp = RESP_OKAY;
            s_next.rdata = 32'h0000_0000;
            unique case (s_axi_araddr_i)
                OFS_LOW_CTRL:  s_next.rdata[15:0] = s_reg.low_ctrl;
                OFS_HIGH_CTRL: s_next.rdata[15:0] = s_reg.high_ctrl;
                OFS_CAP_CTRL:  s_next.rdata[15:0] = cap_status;
                OFS_CAP_BUF:   s_next.rdata[15:0] = s_reg.fifo[s_reg.rd_ptr];
                OFS_CNT_LOW:   s_next.rdata[15:0] = s_reg.cnt_low;
                OFS_CNT_HIGH:  s_next.rdata[15:0] = s_reg.cnt_high;
                OFS_PER_LOW:   s_next.rdata[15:0] = s_reg.per_low;
                OFS_PER_HIGH:  s_next.rdata[15:0] = s_reg.per_high;
                default:       s_next.rresp = RESP_SLVERR;
            endcase
        end
        s_next.arready = ~s_next.rvalid;
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            s_reg <= '0;
            s_reg.low_ctrl <= CTRL_RESET;
            s_reg.high_ctrl <= CTRL_RESET;
            s_reg.cap_ctrl <= CTRL_RESET;
            s_reg.per_low <= PERIOD_RESET;
            s_reg.per_high <= PERIOD_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign s_axi_awready_o  = s_reg.awready;
    assign s_axi_wready_o   = s_reg.wready;
    assign s_axi_bresp_o    = s_reg.bresp;
    assign s_axi_bvalid_o   = s_reg.bvalid;
    assign s_axi_arready_o  = s_reg.arready;
    assign s_axi_rdata_o    = s_reg.rdata;
    assign s_axi_rresp_o    = s_reg.rresp;
    assign s_axi_rvalid_o   = s_reg.rvalid;
    assign capture_irq_o    = s_reg.cap_irq;
    assign timer_low_irq_o  = s_reg.low_irq;
    assign timer_high_irq_o = s_reg.high_irq;
    assign wake_o           = s_reg.wake;

endmodule

// ---- sim/capture_pin_model.sv ----
// far-side model driving clean edges on the capture pin
`timescale 1ns/10ps
module capture_pin_model (
    input  wire logic clk_i,
    output logic      pin_o
);
    initial pin_o = 1'b0;
    // a wide gap mimics a slow external source
    task automatic pulse(input int n, input int gap);
        repeat (n) begin
            pin_o <= 1'b1;
            repeat (gap) @(posedge clk_i);
            pin_o <= 1'b0;
            repeat (gap) @(posedge clk_i);
        end
    endtask
endmodule

// ---- sim/timer_pair_input_capture_checker.sv ----
// bus handshake and wake checks for the timer pair block
`timescale 1ns/10ps
module timer_pair_input_capture_checker (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic sleep_i,
    input wire logic idle_i,
    input wire logic wake_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    sequence aw_taken;
        s_axi_awvalid_i && s_axi_awready_o;
    endsequence
    sequence w_taken;
        s_axi_wvalid_i && s_axi_wready_o;
    endsequence
    sequence r_taken;
        s_axi_rvalid_o && s_axi_rready_i;
    endsequence
    chk_b_after_pair: assert property (aw_taken and w_taken |=> s_axi_bvalid_o)
        else $error("no write response");
    chk_b_cause: assert property ($rose(s_axi_bvalid_o) |-> $past(
        s_axi_awvalid_i && s_axi_awready_o || s_axi_wvalid_i && s_axi_wready_o))
        else $error("response without transfer");
    chk_b_single: assert property (s_axi_bvalid_o && s_axi_bready_i |=>
        !s_axi_bvalid_o) else $error("response repeated");
    chk_r_after_ar: assert property (s_axi_arvalid_i && s_axi_arready_o |=>
        s_axi_rvalid_o) else $error("no read data");
    chk_r_release: assert property (r_taken |=> !s_axi_rvalid_o &&
        s_axi_arready_o) else $error("read not released");
    chk_ar_blocked: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("address taken during data");
    chk_wake_cause: assert property (
        wake_o |-> $past(sleep_i || idle_i)) else $error("wake while awake");
    chk_wake_pulse: assert property (wake_o |=> !wake_o)
        else $error("wake held");
endmodule

bind timer_pair_input_capture timer_pair_input_capture_checker u_chk (
    .clk_i, .rstn_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
    .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i,
    .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i, .sleep_i, .idle_i,
    .wake_o);

// ---- sim/timer_pair_input_capture_tb.sv ----
// self-checking bench for the timer pair with capture channel
`timescale 1ns/10ps
module timer_pair_input_capture_tb;
    import timer_capture_pkg::*;
    logic        clk_i = 1'b0, rstn_i = 1'b0, idle_i = 1'b0, sleep_i = 1'b0;
    logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
    logic        s_axi_arvalid_i = 1'b0;
    logic        s_axi_bready_i = 1'b1, s_axi_rready_i = 1'b1;
    logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
    logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
    logic [3:0]  s_axi_wstrb_i = 4'h3, noise = 4'h0;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, tirq;
    logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, wake_o;
    logic        s_axi_arready_o, s_axi_rvalid_o, capture_irq_o;
    logic        capture_input_pin_i;
    logic [15:0] c, h, q[$];
    logic [7:0]  ofs[3] = '{OFS_LOW_CTRL, OFS_HIGH_CTRL, OFS_CAP_CTRL};
    logic [15:0] msk[3] = '{LOW_CTRL_MASK, HIGH_CTRL_MASK, CAP_CTRL_MASK};
    int          err_total = 0, samples_checked = 0, seed = 57632;
    int          wakes = 0, irqs = 0, ovf = 0, tl = 0, th = 0;

    timer_pair_input_capture dut (.clk_i, .rstn_i, .s_axi_awaddr_i,
        .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
        .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
        .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
        .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
        .idle_i, .sleep_i, .gate_low_i(noise[0]), .gate_high_i(noise[1]),
        .external_count_pin_low_i(noise[2]),
        .external_count_pin_high_i(noise[3]), .capture_input_pin_i,
        .capture_irq_o, .timer_low_irq_o(tirq[0]),
        .timer_high_irq_o(tirq[1]), .wake_o);
    capture_pin_model pins (.clk_i, .pin_o(capture_input_pin_i));

    initial forever #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        noise <= 4'($random(seed));
        if (wake_o === 1'b1) wakes++;
        if (capture_irq_o === 1'b1) irqs++;
        if (tirq[0] === 1'b1) tl++;
        if (tirq[1] === 1'b1) th++;
    end

    task automatic complete_run;
        $display("compared %0d wrong %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic bound(input int n);
        if (n >= 99) begin
            err_total++;
            complete_run;
        end
    endtask
    task automatic check(input string nm, input logic [31:0] s, e);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        int n;
        n = 0;
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= {16'h0000, v};
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
        end while (s_axi_bvalid_o !== 1'b1 && n < 99);
        bound(n);
    endtask
    task automatic rc(input string nm, input logic [7:0] a,
                      input logic [15:0] e, input logic [1:0] re = 2'h0);
        int n;
        n = 0;
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
        end while (s_axi_rvalid_o !== 1'b1 && n < 99);
        bound(n);
        check(nm, {s_axi_rresp_o, s_axi_rdata_o[29:0]}, {re, 14'h0000, e});
    endtask

    initial begin
        repeat (8) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        rc("unmapped", 8'h40, 16'h0000, RESP_SLVERR);
        foreach (ofs[i]) begin
            wr(ofs[i], 16'hFFFF);
            rc("control", ofs[i], msk[i]);
            wr(ofs[i], 16'h0000);
        end
        $display("register test done");
        for (int i = 0; i < 5; i++) begin
            c = 16'($random(seed));
            h = 16'($random(seed));
            wr(OFS_CNT_LOW, c);
            wr(OFS_CNT_HIGH, h);
            wr(OFS_CAP_CTRL, {8'h00, i[0], 7'h03});
            pins.pulse(1, 2);
            if (q.size() < 4) q.push_back(i[0] ? c : h);
            else ovf = 1;
        end
        rc("status", OFS_CAP_CTRL, {11'h000, ovf[0], 4'hB});
        repeat (4) rc("buffer", OFS_CAP_BUF, q.pop_front());
        rc("drained", OFS_CAP_CTRL, 16'h0003);
        // k of 4 runs every-edge mode with the field at 11
        for (int k = 0; k < 5; k++) begin
            wr(OFS_CAP_CTRL, 16'h0000);
            irqs = 0;
            wr(OFS_CAP_CTRL, {9'h000, k[1:0] | {2{k[2]}},
                              k[2] ? 5'h01 : 5'h03});
            pins.pulse(4, 2);
            repeat (4) @(posedge clk_i);
            check("interrupts", irqs, k[2] ? 4 : 4 / (k + 1));
        end
        wr(OFS_CAP_CTRL, 16'h0000);
        irqs = 0;
        sleep_i <= 1'b1;
        wr(OFS_CAP_CTRL, 16'h0007);
        pins.pulse(2, 3);
        repeat (4) @(posedge clk_i);
        check("wakes", wakes, 2);
        check("pin irqs", irqs, 2);
        rc("no capture", OFS_CAP_CTRL, 16'h0007);
        sleep_i <= 1'b0;
        $display("capture test done");
        wr(OFS_CNT_HIGH, 16'h0000);
        wr(OFS_CNT_LOW, 16'hFFFA);
        wr(OFS_HIGH_CTRL, 16'h0072);
        wr(OFS_LOW_CTRL, 16'h8008);
        repeat (10) @(posedge clk_i);
        wr(OFS_LOW_CTRL, 16'h0000);
        rc("carry", OFS_CNT_HIGH, 16'h0001);
        wr(OFS_PER_HIGH, 16'h0001);
        wr(OFS_PER_LOW, 16'h0009);
        wr(OFS_LOW_CTRL, 16'h8008);
        repeat (16) @(posedge clk_i);
        wr(OFS_LOW_CTRL, 16'h0000);
        check("joined match", th, 1);
        check("low match", tl, 0);
        $display("timer test done");
        complete_run;
    end
endmodule
